// ===== rtl/tpps_pin_select.sv
// Function selection for the two shared port-7 pins, bits 5 and 4.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module tpps_pin_select
    import tpps_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic port7_bit5_pin_in,
    output logic port7_bit5_pin_out,
    output logic port7_bit5_pin_oe,
    output logic port7_bit5_pullup_en,
    input wire logic port7_bit4_pin_in,
    output logic port7_bit4_pin_out,
    output logic port7_bit4_pin_oe,
    output logic port7_bit4_pullup_en,
    input wire logic timer2_pulse,
    input wire logic w_phase,
    output logic timer2_input_pin,
    output logic timer2_updown_in,
    output logic timer2_two_phase_in,
    output logic [7:0] three_phase_control,
    output logic [7:0] timer_trigger_select,
    output logic [7:0] updown_flag,
    output logic [7:0] timer2_mode
);
    // ************************************************************
    // Address decode
    // ************************************************************
    // Each register is one aligned word, so the low address bits are zero.
    function automatic logic hit(input logic [11:0] addr,
                                 input logic [9:0] idx);
        hit = (addr == {idx, 2'b00});
    endfunction

    logic [7:0] port7_direction;
    logic [7:0] pullup_control;
    logic [1:0] port7_data;
    logic [1:0] pin_sync;
    logic [7:0] pin_status;

    wire setup_phase = psel && !penable;
    wire wr_en = psel && penable && pwrite && pstrb[0];
    wire hit_tpc = hit(paddr, TPPS_IDX_THREE_PHASE_CONTROL);
    wire hit_tts = hit(paddr, TPPS_IDX_TIMER_TRIGGER_SELECT);
    wire hit_udf = hit(paddr, TPPS_IDX_UPDOWN_FLAG);
    wire hit_tm = hit(paddr, TPPS_IDX_TIMER2_MODE);
    wire hit_dir = hit(paddr, TPPS_IDX_PORT7_DIRECTION);
    wire hit_pu = hit(paddr, TPPS_IDX_PULLUP_CONTROL);
    wire hit_dat = hit(paddr, TPPS_IDX_PORT7_DATA);
    wire hit_sts = hit(paddr, TPPS_IDX_PIN_STATUS);
    wire mapped = hit_tpc | hit_tts | hit_udf | hit_tm | hit_dir | hit_pu
        | hit_dat | hit_sts;

    // ************************************************************
    // Function selection
    // ************************************************************
    wire three_phase = three_phase_control[TPPS_BIT_THREE_PHASE_MODE];
    wire dir5 = port7_direction[TPPS_BIT_PIN5];
    wire dir4 = port7_direction[TPPS_BIT_PIN4];
    wire gate_mode = timer2_mode[TPPS_BIT_MODE_GATE];
    wire pulse_mode = timer2_mode[TPPS_BIT_MODE_PULSE];
    wire two_phase = updown_flag[TPPS_BIT_TWO_PHASE_SEL];
    wire trig_zero = !timer_trigger_select[TPPS_BIT_TRIG_SEL_HI]
        && !timer_trigger_select[TPPS_BIT_TRIG_SEL_LO];
    wire pullup_on = pullup_control[TPPS_BIT_PULLUP_P74_P77];

    // Count source needs no mode bit; gate and pulse use add it.
    wire sel5_timer_in = !three_phase && !dir5 && trig_zero;
    wire sel5_port_in = !three_phase && !dir5;
    wire sel5_port_out = !three_phase && dir5;
    // Pulse output overrides the direction bit of the pin.
    wire sel4_pulse = !three_phase && pulse_mode && !two_phase;
    wire sel4_port = !three_phase && !pulse_mode && !two_phase;
    wire sel4_port_in = sel4_port && !dir4;
    wire sel4_port_out = sel4_port && dir4;
    wire sel4_updown = !three_phase && !dir4 && gate_mode && !pulse_mode
        && !two_phase;
    wire sel4_two_phase = !three_phase && !dir4 && gate_mode && !pulse_mode
        && two_phase;

    wire next_p5_oe = three_phase || sel5_port_out;
    wire next_p5_out = three_phase ? w_phase : port7_data[1];
    wire next_p4_oe = three_phase || sel4_pulse || sel4_port_out;
    wire next_p4_out = three_phase ? w_phase
        : (sel4_pulse ? timer2_pulse : port7_data[0]);
    // A pull-up on a driven pin would only waste current.
    wire next_p5_pu = pullup_on && sel5_port_in;
    wire next_p4_pu = pullup_on && sel4_port_in;

    // Status bits report which selection each pin is in right now.
    assign pin_status = {
        sel4_port_out,
        three_phase,
        sel4_two_phase,
        sel4_updown,
        sel4_pulse,
        sel5_port_out,
        three_phase,
        sel5_timer_in
    };

    // Input bits read the synchronised pin, output bits the latch.
    wire [1:0] data_view = {dir5 ? port7_data[1] : pin_sync[1],
        dir4 ? port7_data[0] : pin_sync[0]};

    wire [7:0] rd_mux =
        hit_tpc ? three_phase_control :
        hit_tts ? timer_trigger_select :
        hit_udf ? updown_flag :
        hit_tm ? timer2_mode :
        hit_dir ? port7_direction :
        hit_pu ? pullup_control :
        hit_dat ? {2'b00, data_view, 4'h0} :
        hit_sts ? pin_status : 8'h00;

    // Pin levels are asynchronous, so logic reads only the second flop.
    tpps_pin_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({port7_bit5_pin_in, port7_bit4_pin_in}),
        .sync_out(pin_sync)
    );

    // ************************************************************
    // APB slave: zero wait states, error on unmapped access.
    // ************************************************************
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Read data is taken in the setup cycle, so the access phase needs no
    // wait state and the data stands until the next setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase) begin
            prdata <= {24'h00_0000, rd_mux};
        end
    end

    // Writes land at the access edge; only byte lane 0 carries a register,
    // so a write without its strobe is dropped without an error.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            three_phase_control <= TPPS_RST_THREE_PHASE_CONTROL;
            timer_trigger_select <= TPPS_RST_TIMER_TRIGGER_SELECT;
            updown_flag <= TPPS_RST_UPDOWN_FLAG;
            timer2_mode <= TPPS_RST_TIMER2_MODE;
            port7_direction <= TPPS_RST_PORT7_DIRECTION;
            pullup_control <= TPPS_RST_PULLUP_CONTROL;
            port7_data <= TPPS_RST_PORT7_DATA;
        end else if (wr_en) begin
            if (hit_tpc) begin
                three_phase_control <= pwdata[7:0];
            end
            if (hit_tts) begin
                timer_trigger_select <= pwdata[7:0];
            end
            if (hit_udf) begin
                updown_flag <= pwdata[7:0];
            end
            if (hit_tm) begin
                timer2_mode <= pwdata[7:0];
            end
            if (hit_dir) begin
                port7_direction <= pwdata[7:0];
            end
            if (hit_pu) begin
                pullup_control <= pwdata[7:0];
            end
            if (hit_dat) begin
                port7_data <= pwdata[5:4];
            end
        end
    end

    // ************************************************************
    // Registered pin and timer-side outputs
    // ************************************************************
    // Timer inputs are held low while their function is not selected, so
    // the timer never sees a pin that belongs to another function.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port7_bit5_pin_out <= 1'b0;
            port7_bit5_pin_oe <= 1'b0;
            port7_bit5_pullup_en <= 1'b0;
            port7_bit4_pin_out <= 1'b0;
            port7_bit4_pin_oe <= 1'b0;
            port7_bit4_pullup_en <= 1'b0;
            timer2_input_pin <= 1'b0;
            timer2_updown_in <= 1'b0;
            timer2_two_phase_in <= 1'b0;
        end else begin
            port7_bit5_pin_out <= next_p5_out;
            port7_bit5_pin_oe <= next_p5_oe;
            port7_bit5_pullup_en <= next_p5_pu;
            port7_bit4_pin_out <= next_p4_out;
            port7_bit4_pin_oe <= next_p4_oe;
            port7_bit4_pullup_en <= next_p4_pu;
            timer2_input_pin <= sel5_timer_in && pin_sync[1];
            timer2_updown_in <= sel4_updown && pin_sync[0];
            timer2_two_phase_in <= sel4_two_phase && pin_sync[0];
        end
    end
endmodule
`default_nettype wire

// ===== rtl/tpps_pkg.sv
// Package with the register map and reset values of the port-7 pin select.
package tpps_pkg;
    // ************************************************************
    // Register indices; the byte address is four times the index.
    // ************************************************************
    localparam logic [9:0] TPPS_IDX_THREE_PHASE_CONTROL = 10'h348;
    localparam logic [9:0] TPPS_IDX_TIMER_TRIGGER_SELECT = 10'h383;
    localparam logic [9:0] TPPS_IDX_UPDOWN_FLAG = 10'h384;
    localparam logic [9:0] TPPS_IDX_TIMER2_MODE = 10'h398;
    localparam logic [9:0] TPPS_IDX_PORT7_DIRECTION = 10'h3EF;
    localparam logic [9:0] TPPS_IDX_PULLUP_CONTROL = 10'h3FD;
    localparam logic [9:0] TPPS_IDX_PORT7_DATA = 10'h300;
    localparam logic [9:0] TPPS_IDX_PIN_STATUS = 10'h301;

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int TPPS_BIT_THREE_PHASE_MODE = 2;
    localparam int TPPS_BIT_TRIG_SEL_HI = 3;
    localparam int TPPS_BIT_TRIG_SEL_LO = 2;
    localparam int TPPS_BIT_TWO_PHASE_SEL = 5;
    localparam int TPPS_BIT_MODE_GATE = 4;
    localparam int TPPS_BIT_MODE_PULSE = 2;
    localparam int TPPS_BIT_PIN5 = 5;
    localparam int TPPS_BIT_PIN4 = 4;
    localparam int TPPS_BIT_PULLUP_P74_P77 = 7;

    // ************************************************************
    // Reset values.
    // ************************************************************
    localparam logic [7:0] TPPS_RST_THREE_PHASE_CONTROL = 8'h00;
    localparam logic [7:0] TPPS_RST_TIMER_TRIGGER_SELECT = 8'h00;
    localparam logic [7:0] TPPS_RST_UPDOWN_FLAG = 8'h00;
    localparam logic [7:0] TPPS_RST_TIMER2_MODE = 8'h00;
    localparam logic [7:0] TPPS_RST_PORT7_DIRECTION = 8'h00;
    localparam logic [7:0] TPPS_RST_PULLUP_CONTROL = 8'h00;
    localparam logic [1:0] TPPS_RST_PORT7_DATA = 2'h0;
    localparam logic [1:0] TPPS_RST_SYNC = 2'h0;
endpackage

// ===== rtl/tpps_pin_sync.sv
// Two-flop synchroniser for the package pin inputs.
`timescale 1ns/1ps
`default_nettype none
module tpps_pin_sync
    import tpps_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] async_in,
    output logic [1:0] sync_out
);
    logic [1:0] meta;

    // The first stage feeds only the second stage.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= TPPS_RST_SYNC;
            sync_out <= TPPS_RST_SYNC;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule
`default_nettype wire

// ===== verif/tpps_checker.sv
// Concurrent checks on the port-7 pin select outputs.
`timescale 1ns/1ps
`default_nettype none
module tpps_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] three_phase_control,
    input wire logic [7:0] timer_trigger_select,
    input wire logic [7:0] updown_flag,
    input wire logic [7:0] timer2_mode,
    input wire logic timer2_pulse,
    input wire logic w_phase,
    input wire logic port7_bit5_pin_out,
    input wire logic port7_bit5_pin_oe,
    input wire logic port7_bit5_pullup_en,
    input wire logic port7_bit4_pin_out,
    input wire logic port7_bit4_pin_oe,
    input wire logic port7_bit4_pullup_en,
    input wire logic timer2_input_pin,
    input wire logic timer2_updown_in,
    input wire logic timer2_two_phase_in
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************************************
    // Selection outputs one edge after cause.
    // ****************************************
    property p_w_drive;
        three_phase_control[2] |=> port7_bit5_pin_oe && port7_bit4_pin_oe
            && port7_bit5_pin_out == $past(w_phase)
            && port7_bit4_pin_out == $past(w_phase);
    endproperty
    property p_w_quiet;
        three_phase_control[2] |=> !(port7_bit5_pullup_en
            || port7_bit4_pullup_en || timer2_input_pin);
    endproperty
    property p_tin;
        timer2_input_pin |-> $past(timer_trigger_select[3:2]) == 2'b00
            && !$past(three_phase_control[2]);
    endproperty
    property p_pulse;
        timer2_mode[2] && !updown_flag[5] && !three_phase_control[2]
            |=> port7_bit4_pin_oe && port7_bit4_pin_out == $past(timer2_pulse);
    endproperty
    property p_two_nodrive;
        updown_flag[5] && !three_phase_control[2] |=> !port7_bit4_pin_oe;
    endproperty
    property p_updown;
        timer2_updown_in |-> $past(timer2_mode[4]) && !$past(timer2_mode[2])
            && !$past(updown_flag[5]) && !$past(three_phase_control[2]);
    endproperty
    property p_two_in;
        timer2_two_phase_in |-> $past(timer2_mode[4])
            && !$past(timer2_mode[2]) && $past(updown_flag[5])
            && !$past(three_phase_control[2]);
    endproperty
    property p_pu5;
        port7_bit5_pullup_en |-> !port7_bit5_pin_oe;
    endproperty
    property p_pu4;
        port7_bit4_pullup_en |-> !port7_bit4_pin_oe;
    endproperty
    a_w_drive: assert property (p_w_drive) else $error("w drive");
    a_w_quiet: assert property (p_w_quiet) else $error("w quiet");
    a_tin: assert property (p_tin) else $error("timer input");
    a_pulse: assert property (p_pulse) else $error("pulse out");
    a_two_nodrive: assert property (p_two_nodrive)
        else $error("pin 4 driven in two-phase mode");
    a_updown: assert property (p_updown) else $error("updown in");
    a_two_in: assert property (p_two_in) else $error("two-phase in");
    a_pu5: assert property (p_pu5) else $error("pull-up bit 5");
    a_pu4: assert property (p_pu4) else $error("pull-up bit 4");
    c_w: cover property (three_phase_control[2] ##1 port7_bit4_pin_oe);
    c_two: cover property ($rose(timer2_two_phase_in));
    c_pulse: cover property ($rose(port7_bit4_pin_oe) && timer2_mode[2]);
endmodule
bind tpps_pin_select tpps_checker u_chk (.pclk, .presetn,
    .three_phase_control, .timer_trigger_select, .updown_flag, .timer2_mode,
    .timer2_pulse, .w_phase, .port7_bit5_pin_out, .port7_bit5_pin_oe,
    .port7_bit5_pullup_en, .port7_bit4_pin_out, .port7_bit4_pin_oe,
    .port7_bit4_pullup_en, .timer2_input_pin, .timer2_updown_in,
    .timer2_two_phase_in);
`default_nettype wire

// ===== verif/tpps_board.sv
// Board model of one shared pin and its external driver.
`timescale 1ns/1ps
`default_nettype none
module tpps_board (
    input wire logic pclk,
    input wire logic oe,
    input wire logic out,
    input wire logic pu,
    input wire logic ext_en,
    input wire logic ext_val,
    output logic lvl
);
    logic flip = 1'b0;
    // A floating pin toggles, so a missed pull-up never reads as steady.
    always @(posedge pclk) flip <= ~flip;
    assign lvl = oe ? out : ext_en ? ext_val : pu ? 1'b1 : flip;
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Testbench for the port-7 pin select.
`timescale 1ns/1ps
`default_nettype none
module tb
    import tpps_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, tp = 1'b0, wp = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic oe5, o5, pu5, oe4, o4, pu4, l5, l4, tin, ud, two;
    logic [1:0] en = 2'b11, ev = 2'b11;
    logic [3:0] strb = 4'hF;
    logic [7:0] tpc, tts, udf, tmd;
    logic [9:0] map [6] = '{10'h348, 10'h383, 10'h384, 10'h398, 10'h3EF,
        10'h3FD};
    int num_errors = 0, checks = 0;
    wire [8:0] pins = {oe5, oe5 & o5, pu5, oe4, oe4 & o4, pu4, tin, ud, two};
    initial forever #2 pclk = ~pclk;
    tpps_pin_select dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb(strb), .prdata, .pready, .pslverr,
        .port7_bit5_pin_in(l5), .port7_bit5_pin_out(o5),
        .port7_bit5_pin_oe(oe5), .port7_bit5_pullup_en(pu5),
        .port7_bit4_pin_in(l4), .port7_bit4_pin_out(o4),
        .port7_bit4_pin_oe(oe4), .port7_bit4_pullup_en(pu4),
        .timer2_pulse(tp), .w_phase(wp), .timer2_input_pin(tin),
        .timer2_updown_in(ud), .timer2_two_phase_in(two),
        .three_phase_control(tpc), .timer_trigger_select(tts),
        .updown_flag(udf), .timer2_mode(tmd));
    tpps_board b5 (.pclk, .oe(oe5), .out(o5), .pu(pu5), .ext_en(en[1]),
        .ext_val(ev[1]), .lvl(l5));
    tpps_board b4 (.pclk, .oe(oe4), .out(o4), .pu(pu4), .ext_en(en[0]),
        .ext_val(ev[0]), .lvl(l4));
    task automatic conclude();
        if (num_errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ****************************************
    // One APB transfer; a read compares data.
    // ****************************************
    task automatic xfer(input logic w, input logic [9:0] a,
                        input logic [7:0] d, input logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {a, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        checks++;
        if (n >= 50 || pslverr !== e || (!w && prdata !== {24'h0, d})) begin
            num_errors++;
            $display("mismatch at %0t: access %h", $time, a);
            if (n >= 50) conclude();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Pin inputs need three edges to reach the timer side, so wait four.
    // It returns on a rising edge, so the next stimulus lands on one.
    task automatic look(input logic [8:0] exp);
        repeat (4) @(posedge pclk);
        #1;
        checks++;
        if (pins !== exp) begin
            num_errors++;
            $display("mismatch at %0t: pins %b want %b", $time, pins, exp);
        end
        @(posedge pclk);
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        foreach (map[i]) xfer(1'b0, map[i], 8'h00, 1'b0);
        xfer(1'b1, 10'h010, 8'hFF, 1'b1);
        xfer(1'b0, 10'h010, 8'h00, 1'b1);
        strb <= 4'h0;
        xfer(1'b1, TPPS_IDX_TIMER_TRIGGER_SELECT, 8'hFF, 1'b0);
        strb <= 4'hF;
        xfer(1'b0, TPPS_IDX_TIMER_TRIGGER_SELECT, 8'h00, 1'b0);
        look(9'b000000100);
        xfer(1'b1, TPPS_IDX_PORT7_DATA, 8'h30, 1'b0);
        xfer(1'b1, TPPS_IDX_PORT7_DIRECTION, 8'h30, 1'b0);
        xfer(1'b1, TPPS_IDX_PULLUP_CONTROL, 8'h80, 1'b0);
        look(9'b110110000);
        en <= 2'b00;
        xfer(1'b1, TPPS_IDX_PORT7_DIRECTION, 8'h00, 1'b0);
        look(9'b001001100);
        xfer(1'b0, TPPS_IDX_PORT7_DATA, 8'h30, 1'b0);
        xfer(1'b1, TPPS_IDX_TIMER_TRIGGER_SELECT, 8'h04, 1'b0);
        look(9'b001001000);
        xfer(1'b1, TPPS_IDX_TIMER_TRIGGER_SELECT, 8'h00, 1'b0);
        xfer(1'b1, TPPS_IDX_PULLUP_CONTROL, 8'h00, 1'b0);
        en <= 2'b11;
        ev <= 2'b11;
        tp <= 1'b1;
        xfer(1'b1, TPPS_IDX_TIMER2_MODE, 8'h04, 1'b0);
        look(9'b000110100);
        tp <= 1'b0;
        look(9'b000100100);
        xfer(1'b1, TPPS_IDX_UPDOWN_FLAG, 8'h20, 1'b0);
        look(9'b000000100);
        xfer(1'b1, TPPS_IDX_TIMER2_MODE, 8'h10, 1'b0);
        look(9'b000000101);
        xfer(1'b1, TPPS_IDX_UPDOWN_FLAG, 8'h00, 1'b0);
        look(9'b000000110);
        xfer(1'b0, TPPS_IDX_PIN_STATUS, 8'h11, 1'b0);
        wp <= 1'b1;
        xfer(1'b1, TPPS_IDX_PULLUP_CONTROL, 8'h80, 1'b0);
        xfer(1'b1, TPPS_IDX_THREE_PHASE_CONTROL, 8'h04, 1'b0);
        look(9'b110110000);
        wp <= 1'b0;
        look(9'b100100000);
        checks++;
        if ({tpc, tts, udf, tmd} !== 32'h0400_0010) begin
            num_errors++;
            $display("mismatch at %0t: register outputs", $time);
        end
        conclude();
    end
endmodule
`default_nettype wire
